// ===== wakeup_down_counter_map.svh
// Register offsets, field positions and reset values of the wake-up down counter
`ifndef WAKEUP_DOWN_COUNTER_MAP_SVH
`define WAKEUP_DOWN_COUNTER_MAP_SVH

// Byte offsets of the register words
`define WDC_OFF_CONTROL 8'h00
`define WDC_OFF_RELOAD 8'h04
`define WDC_OFF_COUNT 8'h08
`define WDC_OFF_IRQ_ENABLE 8'h10
`define WDC_OFF_IRQ_FLAG 8'h14
`define WDC_OFF_IRQ_CLEAR 8'h1c

// Control register fields
`define WDC_CTRL_ENABLE_BIT 0
`define WDC_CTRL_MODE_LSB 1
`define WDC_CTRL_MODE_MSB 2
`define WDC_CTRL_PRESCALE_LSB 4
`define WDC_CTRL_PRESCALE_MSB 7
`define WDC_CTRL_SOURCE_LSB 8
`define WDC_CTRL_SOURCE_MSB 10
`define WDC_CTRL_WIDTH 11
`define WDC_CTRL_WRITE_MASK 11'h7f7

// Underflow bit position in enable, flag and clear registers
`define WDC_UNDERFLOW_BIT 3

// Reset values
`define WDC_RST_CONTROL 11'h000
`define WDC_RST_RELOAD 16'hffff
`define WDC_RST_COUNT 16'h0000
`define WDC_READ_IRQ_CLEAR 32'h0000_003f

`endif

// ===== wakeup_down_counter_pkg.sv
// Types shared by the wake-up down counter modules
package wakeup_down_counter_pkg;

    // Clock source selection codes
    typedef enum logic [2:0] {
        SRC_HIGH_SPEED_INTERNAL = 3'h0,
        SRC_LOW_SPEED_INTERNAL = 3'h1,
        SRC_HIGH_SPEED_EXTERNAL = 3'h2,
        SRC_LOW_SPEED_EXTERNAL = 3'h3,
        SRC_EVENT_PIN = 3'h4
    } clock_source_t;

    // AXI response codes
    typedef enum logic [1:0] {
        RESP_OKAY = 2'h0,
        RESP_SLVERR = 2'h2
    } axi_resp_t;

endpackage : wakeup_down_counter_pkg

// ===== tick_if.sv
// Tick path between the counter core and its prescaler
`timescale 1ns/1ps
interface tick_if;
    logic src_tick;        // One pulse per selected source edge
    logic clear;           // Holds the prescaler at zero
    logic hold;            // Pauses the prescaler
    logic [3:0] code;      // Prescale select code
    logic prescaled_tick;  // One pulse per divided period

    modport core (output src_tick, output clear, output hold, output code, input prescaled_tick);
    modport divider (input src_tick, input clear, input hold, input code, output prescaled_tick);
endinterface : tick_if

// ===== edge_sync.sv
// Three-stage synchroniser with rising-edge pulse, one per input bit
`timescale 1ns/1ps
module edge_sync #(
    parameter int WIDTH = 5
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Asynchronous levels in, one-cycle pulses out
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] rise_pulse
);

    // Refuse a width that the bit loop cannot build
    if (WIDTH < 1) begin : g_bad_width
        $error("edge_sync: WIDTH must be at least 1");
    end

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic s1, s2, s3;   // Synchroniser chain
            logic settled;      // Last agreed level
            wire agree = (s2 == s3);  // Change counts once stages two and three match
            // First stage is read by the second stage only
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    s1 <= 1'b0;
                    s2 <= 1'b0;
                    s3 <= 1'b0;
                    settled <= 1'b0;
                end else begin
                    s1 <= async_in[i];
                    s2 <= s1;
                    s3 <= s2;
                    if (agree) settled <= s3;
                end
            end
            assign rise_pulse[i] = agree & s3 & ~settled;
        end
    endgenerate

endmodule : edge_sync

// ===== tick_prescaler.sv
// Power-of-two prescaler on the selected source pulses
`timescale 1ns/1ps
module tick_prescaler #(
    parameter int DIV_BITS = 15
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Tick path from the core
    tick_if.divider tk
);

    // Code 15 needs fifteen divider bits; this sets the longest period
    if (DIV_BITS < 15) begin : g_bad_bits
        $error("tick_prescaler: DIV_BITS must be at least 15");
    end

    logic [DIV_BITS-1:0] div_count;  // Source pulses outside hold since the timer was enabled
    logic [DIV_BITS-1:0] div_mask;   // Low code bits set

    // Code n divides by 2**n; reserved code 0 degenerates to no division
    assign div_mask = DIV_BITS'((32'h1 << tk.code) - 32'h1);
    assign tk.prescaled_tick = tk.src_tick & ~tk.hold & ~tk.clear
                               & ((div_count & div_mask) == div_mask);

    // Free count of source pulses, cleared while the timer is off
    always_ff @(posedge aclk) begin
        if (!aresetn || tk.clear) begin
            div_count <= '0;
        end else if (tk.src_tick && !tk.hold) begin
            div_count <= div_count + 1'b1;
        end
    end

endmodule : tick_prescaler

// ===== wakeup_down_counter.sv
// Wake-up down counter: AXI4-Lite register bank, source select, counter and flags
//
// How it works
// - Source code picks one of five clocks.
// - Prescaler divides source by two to the code.
// - Each period lasts reload plus one ticks.
// - Enable loads reload, then decrements per tick.
// - A tick at zero raises underflow and sets flag.
// - Underflow reloads counter and restarts countdown.
// - Reload writes only affect the next period.
// - Interrupt only when flag and enable bit.
// - Flag reads at bit three, read-only.
// - Writing zero to clear bit clears flag.
// - Clearing enable stops counting.
// - Low-speed source keeps running, underflow wakes system.
// - Low-speed period spans microseconds to many hours.
// - Freeze bit suspends counting during debug halt.
// - Reload resets to ffff; count reads live.
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "wakeup_down_counter_map.svh"
module wakeup_down_counter (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic [2:0] awprot,
    // AXI4-Lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // AXI4-Lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    input wire logic [2:0] arprot,
    // AXI4-Lite read data
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // Clock sources and event pin, all asynchronous levels
    input wire logic high_speed_internal_osc,
    input wire logic low_speed_internal_osc,
    input wire logic high_speed_external_osc,
    input wire logic low_speed_external_osc,
    input wire logic event_input_pin,
    // Debug and low-power controller
    input wire logic debug_halted,
    input wire logic debug_freeze_control,
    input wire logic deep_sleep_mode,
    // Events out
    output logic irq,
    output logic wakeup_request,
    output logic underflow_pulse
);

    // Bus write holding state
    logic aw_held;            // Write address accepted
    logic [7:0] aw_addr;      // Held write address
    logic w_held;             // Write data accepted
    logic [31:0] w_data;      // Held write data
    logic [3:0] w_strb;       // Held byte strobes
    // Registers
    logic [`WDC_CTRL_WIDTH-1:0] ctrl;  // Control word
    logic [15:0] reload_value;         // Reload register
    logic [15:0] count_value;          // Live counter
    logic irq_enable;                  // Underflow interrupt enable
    logic flag_ud;                     // Sticky underflow flag
    logic enable_q;                    // Enable one cycle ago

    // Field views of the control word
    wire enable = ctrl[`WDC_CTRL_ENABLE_BIT];
    wire [3:0] prescale_select = ctrl[`WDC_CTRL_PRESCALE_MSB:`WDC_CTRL_PRESCALE_LSB];
    wire [2:0] clock_source_select = ctrl[`WDC_CTRL_SOURCE_MSB:`WDC_CTRL_SOURCE_LSB];

    // Write decode
    wire do_write = aw_held & w_held & ~bvalid;
    wire wr_ctrl = do_write & (aw_addr == `WDC_OFF_CONTROL);
    wire wr_reload = do_write & (aw_addr == `WDC_OFF_RELOAD);
    wire wr_ier = do_write & (aw_addr == `WDC_OFF_IRQ_ENABLE);
    wire wr_icr = do_write & (aw_addr == `WDC_OFF_IRQ_CLEAR);
    // Count and flag words are read-only, so only these four accept a write
    wire wr_ok = wr_ctrl | wr_reload | wr_ier | wr_icr;

    // Byte-lane merge of held write data into an old word
    function automatic logic [31:0] merge_bytes(input logic [31:0] old_word,
                                                input logic [31:0] new_word,
                                                input logic [3:0] strb);
        logic [31:0] res;
        res = old_word;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) res[8*b +: 8] = new_word[8*b +: 8];
        end
        return res;
    endfunction : merge_bytes

    wire [31:0] ctrl_merged = merge_bytes({21'h0, ctrl}, w_data, w_strb);
    wire [31:0] reload_merged = merge_bytes({16'h0, reload_value}, w_data, w_strb);
    // Reserved bit 3 of the control word stays zero
    wire [`WDC_CTRL_WIDTH-1:0] next_ctrl = ctrl_merged[`WDC_CTRL_WIDTH-1:0]
                                           & `WDC_CTRL_WRITE_MASK;
    // Clear-bit write of zero in the low byte lane
    wire clear_flag = wr_icr & w_strb[0] & ~w_data[`WDC_UNDERFLOW_BIT];

    // Source selection and pin synchronisers
    logic [4:0] src_pulse;  // Rising edge of each source
    edge_sync #(.WIDTH(5)) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in({event_input_pin, low_speed_external_osc, high_speed_external_osc,
                   low_speed_internal_osc, high_speed_internal_osc}),
        .rise_pulse(src_pulse)
    );

    // Unused codes 5..7 select nothing, so no tick arrives
    wire selected_pulse = (clock_source_select <= 3'(wakeup_down_counter_pkg::SRC_EVENT_PIN))
                          ? src_pulse[clock_source_select] : 1'b0;
    // Low-speed sources are the ones kept alive in deep sleep
    wire low_speed_src =
        (clock_source_select == 3'(wakeup_down_counter_pkg::SRC_LOW_SPEED_INTERNAL)) ||
        (clock_source_select == 3'(wakeup_down_counter_pkg::SRC_LOW_SPEED_EXTERNAL));

    // Counting conditions
    wire freeze = debug_freeze_control & debug_halted;
    wire load = enable & ~enable_q;
    wire tick;                                           // Prescaled tick
    wire run_tick = tick & enable & ~freeze & ~load;
    wire underflow = run_tick & (count_value == 16'h0000);

    // Prescaler on the tick path
    tick_if tk ();
    assign tk.src_tick = selected_pulse;
    assign tk.clear = ~enable;
    assign tk.hold = freeze;
    assign tk.code = prescale_select;
    assign tick = tk.prescaled_tick;
    tick_prescaler u_prescale (
        .aclk(aclk),
        .aresetn(aresetn),
        .tk(tk.divider)
    );

    // Bus handshake: accept each channel once, answer when both are held
    assign awready = ~aw_held;
    assign wready = ~w_held;
    assign arready = ~rvalid;

    // Write address and data capture; response after both
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            bvalid <= 1'b0;
            bresp <= 2'h0;
        end else begin
            if (awvalid && awready) begin
                aw_held <= 1'b1;
                aw_addr <= awaddr;
            end else if (do_write) begin
                aw_held <= 1'b0;
            end
            if (wvalid && wready) begin
                w_held <= 1'b1;
                w_data <= wdata;
                w_strb <= wstrb;
            end else if (do_write) begin
                w_held <= 1'b0;
            end
            if (do_write) begin
                bvalid <= 1'b1;
                // Read-only and unmapped words refuse writes
                bresp <= wr_ok
                         ? wakeup_down_counter_pkg::RESP_OKAY
                         : wakeup_down_counter_pkg::RESP_SLVERR;
            end else if (bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // Read mux
    logic [31:0] read_word;   // Word at araddr
    logic read_hit;           // Address is mapped
    always_comb begin
        read_word = 32'h0000_0000;
        read_hit = 1'b1;
        unique case (araddr)
            `WDC_OFF_CONTROL: read_word = {21'h0, ctrl};
            `WDC_OFF_RELOAD: read_word = {16'h0, reload_value};
            `WDC_OFF_COUNT: read_word = {16'h0, count_value};
            `WDC_OFF_IRQ_ENABLE: read_word[`WDC_UNDERFLOW_BIT] = irq_enable;
            `WDC_OFF_IRQ_FLAG: read_word[`WDC_UNDERFLOW_BIT] = flag_ud;
            `WDC_OFF_IRQ_CLEAR: read_word = `WDC_READ_IRQ_CLEAR;
            default: read_hit = 1'b0;
        endcase
    end

    // Read answer one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= 2'h0;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata <= read_word;
            rresp <= read_hit ? wakeup_down_counter_pkg::RESP_OKAY
                              : wakeup_down_counter_pkg::RESP_SLVERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    // Software registers; source and prescale changes mid-run are the user's hazard
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl <= `WDC_RST_CONTROL;
            reload_value <= `WDC_RST_RELOAD;
            irq_enable <= 1'b0;
        end else begin
            if (wr_ctrl) ctrl <= next_ctrl;
            // Only the register changes; the counter picks it up at reload
            if (wr_reload) reload_value <= reload_merged[15:0];
            if (wr_ier && w_strb[0]) irq_enable <= w_data[`WDC_UNDERFLOW_BIT];
        end
    end

    // Down counter
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_value <= `WDC_RST_COUNT;
            enable_q <= 1'b0;
        end else begin
            enable_q <= enable;
            if (load) begin
                count_value <= reload_value;
            end else if (underflow) begin
                count_value <= reload_value;
            end else if (run_tick) begin
                count_value <= count_value - 16'h0001;
            end
        end
    end

    // Flag and event outputs; a set in the clear cycle wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flag_ud <= 1'b0;
            irq <= 1'b0;
            wakeup_request <= 1'b0;
            underflow_pulse <= 1'b0;
        end else begin
            if (underflow) flag_ud <= 1'b1;
            else if (clear_flag) flag_ud <= 1'b0;
            irq <= flag_ud & irq_enable;
            wakeup_request <= flag_ud & low_speed_src & deep_sleep_mode;
            underflow_pulse <= underflow;
        end
    end

    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_load_on_enable: assert property (load |=> count_value == $past(reload_value))
        else $error("Counter not loaded on enable");
    a_reload_at_zero: assert property (underflow |=> count_value == $past(reload_value))
        else $error("Counter not reloaded after underflow");
    a_step_down: assert property (run_tick && count_value != 16'h0000
                                  |=> count_value == $past(count_value) - 16'h0001)
        else $error("Counter did not decrement by one");
    a_flag_follows: assert property (underflow |=> flag_ud && underflow_pulse)
        else $error("Underflow flag not set");
    a_flag_clears: assert property (clear_flag && !underflow |=> !flag_ud)
        else $error("Flag not cleared by write of zero");
    a_irq_gated: assert property (irq |-> $past(flag_ud) && $past(irq_enable))
        else $error("Interrupt without flag and enable");
    a_irq_raised: assert property ((flag_ud && irq_enable) [*2] |-> irq)
        else $error("Interrupt missing");
    a_hold_off: assert property (!enable && !$past(enable) |-> $stable(count_value))
        else $error("Counter moved while disabled");
    a_freeze_hold: assert property (freeze && !load |=> $stable(count_value))
        else $error("Counter moved during debug freeze");
    a_wake_source: assert property (wakeup_request |-> $past(low_speed_src))
        else $error("Wake request from fast source");

    c_underflow: cover property (underflow);
    c_clear_race: cover property (underflow && clear_flag);
    c_event_tick: cover property (run_tick
        && clock_source_select == 3'(wakeup_down_counter_pkg::SRC_EVENT_PIN));
    c_wake: cover property (wakeup_request);

endmodule : wakeup_down_counter

// ===== event_source_model.sv
// Far-side model: event pin source and low-power controller
`timescale 1ns/1ps
module event_source_model (
    // Clock
    input wire logic aclk,
    // Requests from the bench
    input wire logic fire,
    input wire logic slow,
    input wire logic sleep_req,
    // Levels toward the counter, busy flag toward the bench
    output logic event_input_pin,
    output logic deep_sleep_mode,
    output logic pin_busy
);
    int phase = 0; // Cycles left in the pulse
    int hold = 4; // Cycles per level
    initial event_input_pin = 1'h0;
    initial deep_sleep_mode = 1'h0;
    initial pin_busy = 1'h0;
    // One pulse per request; both levels last at least two cycles or the sync drops it
    always @(posedge aclk) begin
        if (fire && !pin_busy) begin
            hold = slow ? 8 : 4;
            phase <= 2 * hold;
            pin_busy <= 1'h1;
            event_input_pin <= 1'h1;
        end else if (phase > 0) begin
            phase <= phase - 1;
            if (phase == hold + 1) event_input_pin <= 1'h0;
            if (phase == 1) pin_busy <= 1'h0;
        end
    end
    // Sleep level follows the request one cycle later
    always @(posedge aclk) deep_sleep_mode <= sleep_req;
endmodule : event_source_model

// ===== wakeup_down_counter_bench.sv
// Self-checking bench of the wake-up down counter against an integer model
`timescale 1ns/1ps
`define CHK(n, e, g) check_val(n, 32'(e), 32'(g))
module wakeup_down_counter_bench;
    // Bus and pin stimulus
    logic aclk = 1'h0, aresetn = 1'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic [7:0] awaddr = 8'h0, araddr = 8'h0;
    logic [2:0] awprot = 3'h0, arprot = 3'h0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid, irq, wakeup_request, underflow_pulse;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] rdata, rd;
    logic high_speed_internal_osc = 1'h0, low_speed_internal_osc = 1'h0;
    logic high_speed_external_osc = 1'h0, low_speed_external_osc = 1'h0;
    logic debug_halted = 1'h0, debug_freeze_control = 1'h0;
    logic fire = 1'h0, slow = 1'h0, sleep_req = 1'h0;
    logic event_input_pin, deep_sleep_mode, pin_busy;
    logic [5:0] osc_div = 6'h0;
    logic [31:0] seed = 32'h02221380;
    // Model state and counters
    int errors = 0, checks = 0, cycles = 0, uf_seen = 0;
    int cnt, reload, code, edges, en, flag;
    int uf_log[$]; // Reload value taken at each modelled underflow
    logic [7:0] ra[6] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h1c};
    logic [31:0] rv[6] = '{32'h0, 32'hffff, 32'h0, 32'h0, 32'h0, 32'h3f};

    wakeup_down_counter uut (.*);
    event_source_model far_side (.*);

    // Clock, free-running oscillators, pulse counter and watchdog
    always #20 aclk = ~aclk;
    always @(posedge aclk) begin
        osc_div <= osc_div + 6'h1;
        high_speed_internal_osc <= osc_div[2];
        high_speed_external_osc <= osc_div[3];
        low_speed_internal_osc <= osc_div[4];
        low_speed_external_osc <= osc_div[5];
        if (underflow_pulse === 1'h1) uf_seen <= uf_seen + 1;
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            stop_test();
        end
    end

    // Compare and count
    task check_val(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : check_val

    // Verdict and end of run
    task stop_test();
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : stop_test

    // Xorshift step for random stimulus
    function automatic logic [31:0] next_rand(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction : next_rand

    // AXI4-Lite write; address and data offered together, each released when taken
    task axi_write(input logic [7:0] a, input logic [31:0] d);
        bit aw, w;
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        aw = 0;
        w = 0;
        while (!(aw && w)) begin
            @(posedge aclk);
            if (!aw && awready) begin
                aw = 1;
                awvalid <= 1'h0;
            end
            if (!w && wready) begin
                w = 1;
                wvalid <= 1'h0;
            end
        end
        bready <= 1'h1;
        do @(posedge aclk); while (bvalid !== 1'h1);
        resp = bresp;
        bready <= 1'h0;
    endtask : axi_write

    // AXI4-Lite read into rd and resp
    task axi_read(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'h1;
        do @(posedge aclk); while (arready !== 1'h1);
        arvalid <= 1'h0;
        rready <= 1'h1;
        do @(posedge aclk); while (rvalid !== 1'h1);
        rd = rdata;
        resp = rresp;
        rready <= 1'h0;
    endtask : axi_read

    // Model: one pin edge through prescaler and counter; paused when frozen or off
    task model_edge();
        if (en && !(debug_halted && debug_freeze_control)) begin
            edges++;
            if (edges == (1 << code)) begin
                edges = 0;
                if (cnt == 0) begin
                    cnt = reload;
                    flag = 1;
                    uf_log.push_back(cnt);
                end else cnt--;
            end
        end
    endtask : model_edge

    // Send n pulses at random pace, then check count, flag, clear and irq
    task run_block(input int n);
        repeat (n) begin
            seed = next_rand(seed);
            slow <= seed[0];
            fire <= 1'h1;
            @(posedge aclk);
            fire <= 1'h0;
            @(posedge aclk);
            while (pin_busy) @(posedge aclk);
            model_edge();
        end
        repeat (8) @(posedge aclk);
        axi_read(8'h08);
        `CHK("count", cnt, rd);
        `CHK("irq", flag, irq);
        axi_write(8'h1c, 32'h8); // Writing one leaves the flag alone
        axi_read(8'h14);
        `CHK("flag", flag << 3, rd);
        axi_write(8'h1c, 32'h0);
        flag = 0;
    endtask : run_block

    // Main sequence
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        for (int i = 0; i < 6; i++) begin
            axi_read(ra[i]);
            `CHK("reset value", rv[i], rd);
        end
        axi_read(8'h0c);
        `CHK("unmapped read", 32'h2, {rd[29:0], resp});
        axi_write(8'h08, 32'h1234);
        `CHK("count write", 32'h2, resp);
        axi_write(8'h14, 32'hffffffff);
        `CHK("flag write", 32'h2, resp);
        axi_write(8'h00, 32'hfffffffe);
        axi_read(8'h00);
        `CHK("control field", 32'h7f6, rd);
        axi_write(8'h00, 32'h0);
        axi_write(8'h10, 32'h8);
        debug_freeze_control <= 1'h1; // Keeps a halted session quiet
        for (code = 1; code <= 3; code++) begin
            seed = next_rand(seed);
            reload = seed[1:0]; // N events need N minus one
            axi_write(8'h04, reload);
            axi_write(8'h00, 32'h406 | (code << 4)); // Source, prescale, mode first
            axi_write(8'h00, 32'h407 | (code << 4));
            cnt = reload;
            edges = 0;
            en = 1;
            flag = 0;
            run_block(1 + seed[4:2]);
            reload = seed[9:8]; // Takes effect at the next reload only
            axi_write(8'h04, reload);
            run_block(4 + seed[6:5]);
            debug_halted <= 1'h1; // Frozen, then free while halted
            run_block(3);
            debug_freeze_control <= 1'h0;
            run_block(2);
            debug_halted <= 1'h0;
            debug_freeze_control <= 1'h1;
            axi_write(8'h00, 32'h406 | (code << 4)); // Off: count holds
            en = 0;
            run_block(3);
        end
        `CHK("underflow pulses", uf_log.size(), uf_seen);
        sleep_req <= 1'h1;
        for (int s = 0; s < 6; s++) begin
            if (s == 4) continue;
            axi_write(8'h00, 32'h0);
            axi_write(8'h1c, 32'h0);
            axi_write(8'h10, (s % 2) ? 32'h8 : 32'h0);
            axi_write(8'h04, 32'h1);
            axi_write(8'h00, 32'h17 | (s << 8));
            repeat (400) @(posedge aclk);
            axi_read(8'h14);
            `CHK("source flag", (s < 4) << 3, rd);
            `CHK("source irq", (s < 4) && (s % 2), irq);
            `CHK("wakeup", s == 1 || s == 3, wakeup_request);
        end
        stop_test();
    end
endmodule : wakeup_down_counter_bench
